// File: nfc_frame_codec_fifo_bench.sv
/* self-checking bench for the frame codec with its shared fifo.
   assumes the host model file and the package are compiled first. */
module nfc_frame_codec_fifo_bench
    import nfcfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, osc_en = 1, tx_start = 0, fifo_flush = 0, wv = 0, i2c_en = 0;
    logic spi_mosi = 0, port_miso = 0, port_miso_oe = 0, rx_frame = 0, rx_bit = 0, rx_bv = 0;
    logic wr_ready, rd_valid, rd_ready, spi_miso, spi_miso_oe, spi_active, mod_out, tx_busy;
    logic [7:0] wd = 8'h00;
    logic [7:0] rd_data;
    logic [9:0] level;
    nfcfc_cfg_s cfg = '0;
    nfcfc_stat_s stat;
    logic [7:0] exp_q[$];
    int err_total = 0, total_checks = 0;

    nfcfc_codec DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .osc_en(osc_en), .tx_start(tx_start),
        .fifo_flush(fifo_flush), .host_wr_valid(wv), .host_wr_data(wd), .host_wr_ready(wr_ready),
        .host_rd_valid(rd_valid), .host_rd_data(rd_data), .host_rd_ready(rd_ready), .fifo_level(level),
        .i2c_en(i2c_en), .spi_mosi(spi_mosi), .port_miso(port_miso), .port_miso_oe(port_miso_oe),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .spi_active(spi_active), .rx_frame(rx_frame),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bv), .mod_out(mod_out), .tx_busy(tx_busy), .stat(stat));
    nfcfc_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .rd_valid(rd_valid), .rd_ready(rd_ready));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // host byte write, held until taken
    task automatic put(input logic [7:0] b);
        int n = 0;
        @(negedge sys_clk);
        wv = 1'b1;
        wd = b;
        do @(posedge sys_clk); while (wr_ready !== 1'b1 && ++n < 100);
        chk(wr_ready, 1'b1);
        @(negedge sys_clk);
        wv = 1'b0;
    endtask
    // one byte of digitized bits, lsb first, byte noted as expected
    task automatic rbyte(input logic [7:0] b, input int nb);
        exp_q.push_back(b);
        for (int i = 0; i < nb; i++)
        begin
            @(negedge sys_clk);
            rx_bit = (i < 8) ? b[i] : ~^b;
            rx_bv = 1'b1;
            @(negedge sys_clk);
            rx_bv = 1'b0;
        end
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction
    // framed receive with crc appended low byte first
    task automatic rx_test(input logic bad, input nfcfc_proto_e p);
        logic [15:0] c;
        logic [7:0] b;
        int n = 0;
        c = (p == NFCFC_PROTO_A) ? CRC_INIT_A : CRC_INIT_X;
        cfg = '{mode: NFCFC_FRAMED, proto: p, rate: 2'h0, dir_rx: 1'b1, tx_len: 13'h1};
        @(negedge sys_clk);
        rx_frame = 1'b1;
        @(negedge sys_clk);
        rx_bit = RX_SOF_BIT;
        rx_bv = 1'b1;
        @(negedge sys_clk);
        rx_bv = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            b = 8'($urandom);
            c = crc(c, b);
            rbyte(b, (p == NFCFC_PROTO_A) ? 9 : 8);
        end
        rbyte(c[7:0], (p == NFCFC_PROTO_A) ? 9 : 8);
        rbyte(c[15:8] ^ {bad, 7'h00}, (p == NFCFC_PROTO_A) ? 9 : 8);
        @(negedge sys_clk);
        rx_frame = 1'b0;
        do @(negedge sys_clk); while (stat.rx_done !== 1'b1 && ++n < 20);
        chk({stat.sof_err, stat.eof_err, stat.par_err, stat.crc_err}, {3'h0, bad});
        drain();
    endtask
    task automatic drain();
        for (int n = 0; n < 500 && exp_q.size() > 0; n++)
            @(negedge sys_clk);
        chk(exp_q.size(), 0);
    endtask
    // one-byte transmit, bits sampled mid period, rate 3 gives 118 cycles
    task automatic tx_test(input nfcfc_mode_e m);
        logic [7:0] b = 8'($urandom);
        int n = 0;
        cfg = '{mode: m, proto: NFCFC_PROTO_A, rate: 2'h3, dir_rx: 1'b0, tx_len: 13'h1};
        put(b);
        @(negedge sys_clk);
        tx_start = 1'b1;
        @(negedge sys_clk);
        tx_start = 1'b0;
        repeat (59) @(negedge sys_clk);
        if (m == NFCFC_FRAMED)
            chk(mod_out, SOF_LVL);
        repeat (m == NFCFC_FRAMED ? 119 : 1) @(negedge sys_clk);
        for (int i = 0; i < (m == NFCFC_FRAMED ? 9 : 8); i++)
        begin
            chk(mod_out, i < 8 ? b[i] : ~^b);
            if (i < (m == NFCFC_FRAMED ? 8 : 7))
                repeat (118) @(negedge sys_clk);
        end
        do @(negedge sys_clk); while (stat.tx_done !== 1'b1 && ++n < 4000);
        chk({stat.tx_done, tx_busy, level}, 12'h800);
        $display("tx test done");
    endtask

    always @(posedge sys_clk)
        if (rst_n && rd_valid === 1'b1 && rd_ready)
            chk(rd_data, exp_q.size() ? exp_q.pop_front() : 16'hdead);

    initial forever #5 sys_clk = ~sys_clk;
    initial
    begin
        #200_000;
        err_total++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'hce69722f));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        chk({mod_out, rd_valid, level}, 12'h800);
        osc_en = 1'b0;
        #1 chk(wr_ready, 1'b0);
        osc_en = 1'b1;
        for (int i = 0; i < FIFO_BYTES + 2; i++)
            put(8'(i));
        @(negedge sys_clk);
        chk({wr_ready, level}, FIFO_BYTES);
        fifo_flush = 1'b1;
        @(negedge sys_clk);
        fifo_flush = 1'b0;
        @(negedge sys_clk);
        chk(level, 0);
        $display("fifo test done");
        tx_test(NFCFC_STREAM);
        tx_test(NFCFC_FRAMED);
        rx_test(1'b0, NFCFC_PROTO_B);
        rx_test(1'b0, NFCFC_PROTO_A);
        rx_test(1'b1, NFCFC_PROTO_B);
        cfg.mode = NFCFC_STREAM;
        for (int i = 0; i < 3; i++)
            rbyte(8'($urandom), 8);
        drain();
        chk(wr_ready, 1'b0);
        $display("rx test done");
        cfg.mode = NFCFC_TRANSP;
        repeat (16)
        begin
            @(negedge sys_clk);
            {cfg.dir_rx, spi_mosi, rx_bit, i2c_en, port_miso} = 5'($urandom);
            #1 chk(spi_active, !i2c_en);
            if (!cfg.dir_rx)
                chk(mod_out, spi_mosi);
            else if (!i2c_en)
                chk({spi_miso, spi_miso_oe}, {rx_bit, 1'b1});
        end
        $display("transparent test done");
        complete_run();
    end
endmodule

// File: nfcfc_codec.sv
/*
 * nfc frame codec: transmit encoder and receive decoder around the shared fifo,
 * with framed, stream and transparent modes and host pin selection.
 * assumes the host port logic outside moves bytes over the host byte ports,
 * and the rf side gives one digitized bit per rx_bit_valid.
 */
module nfcfc_codec
    import nfcfc_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_BYTES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire nfcfc_cfg_s cfg,
    input wire logic osc_en,
    input wire logic tx_start,
    input wire logic fifo_flush,
    input wire logic host_wr_valid,
    input wire logic [7:0] host_wr_data,
    output logic host_wr_ready,
    output logic host_rd_valid,
    output logic [7:0] host_rd_data,
    input wire logic host_rd_ready,
    output logic [$clog2(FIFO_DEPTH):0] fifo_level,
    input wire logic i2c_en,
    input wire logic spi_mosi,
    input wire logic port_miso,
    input wire logic port_miso_oe,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic spi_active,
    input wire logic rx_frame,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    output logic mod_out,
    output logic tx_busy,
    output nfcfc_stat_s stat
);
    if (FIFO_DEPTH != FIFO_BYTES)
    begin : g_bad
        $error("nfcfc_codec: fifo depth must be 512");
    end

    typedef struct packed {
        nfcfc_tx_e ts;
        logic [11:0] tmr;
        logic [7:0] sh;
        logic [3:0] nb;
        logic txp;
        logic [LEN_W-1:0] left;
        logic [1:0] ph;
        logic [15:0] crc;
        logic mod;
        logic [1:0] bv;
        logic [15:0] bd;
        logic [7:0] rsh;
        logic [3:0] rnb;
        logic [15:0] rcrc;
        logic rin;
        logic rsof;
        logic rfp;
        logic rwr;
        logic [7:0] rdat;
        nfcfc_stat_s st;
    } nfcfc_state_s;

    nfcfc_state_s r, next_r;
    logic f_wr_valid, f_wr_ready, f_rd_valid, f_rd_ready;
    logic [7:0] f_wr_data, f_rd_data;
    logic framed, par_en, tx_en, rx_act, transp, tick, adv, tx_pop, host_pop, push;
    logic [11:0] per;
    logic [15:0] crc_init;
    logic [7:0] byt;
    logic [1:0] nph;
    logic [$clog2(FIFO_DEPTH):0] fifo_lvl_w;

    // ------------------------------------------------------------------
    // mode decode and shared fifo steering
    // ------------------------------------------------------------------
    assign framed = (cfg.mode == NFCFC_FRAMED);
    assign transp = (cfg.mode == NFCFC_TRANSP);
    assign par_en = (cfg.proto == NFCFC_PROTO_A);
    assign crc_init = par_en ? CRC_INIT_A : CRC_INIT_X;
    assign per = (BIT_CYC >> cfg.rate) - 12'h001;
    assign tx_en = osc_en && !cfg.dir_rx && !transp;
    assign rx_act = osc_en && cfg.dir_rx && !transp;
    assign tick = (r.tmr == 12'h000);
    assign spi_active = !i2c_en;
    // one writer and one reader per direction
    assign f_wr_valid = cfg.dir_rx ? r.rwr : (host_wr_valid && osc_en);
    assign f_wr_data = cfg.dir_rx ? r.rdat : host_wr_data;
    assign host_wr_ready = !cfg.dir_rx && osc_en && f_wr_ready;
    assign host_rd_valid = cfg.dir_rx && osc_en && r.bv[0];
    assign host_rd_data = r.bd[7:0];
    assign host_pop = host_rd_valid && host_rd_ready;
    assign f_rd_ready = !r.bv[1] && osc_en;
    assign push = f_rd_valid && f_rd_ready;
    assign tx_busy = (r.ts != TX_IDLE);
    assign stat = r.st;
    assign fifo_level = ($clog2(FIFO_DEPTH)+1)'(fifo_lvl_w);
    // transparent paths bypass framing and fifo
    assign mod_out = (transp && !cfg.dir_rx) ? spi_mosi : r.mod;
    assign spi_miso = (transp && cfg.dir_rx) ? rx_bit : port_miso;
    assign spi_miso_oe = spi_active && ((transp && cfg.dir_rx) || port_miso_oe);


    nfcfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .wr_valid(f_wr_valid),
        .wr_data(f_wr_data),
        .wr_ready(f_wr_ready),
        .rd_valid(f_rd_valid),
        .rd_data(f_rd_data),
        .rd_ready(f_rd_ready),
        .level(fifo_lvl_w)
    );

    // ------------------------------------------------------------------
    // next state: encoder, two-entry buffer, decoder
    // ------------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.st.tx_done = 1'b0;
        next_r.st.rx_done = 1'b0;
        next_r.rwr = 1'b0;
        next_r.rfp = rx_frame;
        next_r.tmr = tick ? per : r.tmr - 12'h001;
        adv = 1'b0;
        tx_pop = 1'b0;
        nph = r.ph;
        byt = r.bd[7:0];
        case (r.ts)
            TX_IDLE:
            begin
                next_r.mod = IDLE_LVL;
                if (tx_start && tx_en && cfg.tx_len != '0)
                begin
                    next_r.left = cfg.tx_len;
                    next_r.ph = PH_DATA;
                    next_r.crc = crc_init;
                    next_r.tmr = per;
                    next_r.ts = framed ? TX_SOF : TX_LOAD;
                    next_r.mod = framed ? SOF_LVL : IDLE_LVL;
                end
            end
            TX_SOF:
            begin
                if (tick)
                begin
                    next_r.ts = TX_LOAD;
                end
            end
            TX_LOAD:
            begin
                // in the data phase, stalls until the buffer offers a payload byte; crc bytes load at once
                if (r.ph != PH_DATA || r.bv[0])
                begin
                    byt = (r.ph == PH_DATA) ? r.bd[7:0] : (r.ph == PH_CRC_LO) ? r.crc[7:0] : r.crc[15:8];
                    tx_pop = (r.ph == PH_DATA);
                    if (r.ph == PH_DATA && framed)
                    begin
                        next_r.crc = nfcfc_crc_byte(r.crc, byt);
                    end
                    next_r.sh = byt;
                    next_r.txp = ~^byt;
                    next_r.mod = byt[0];
                    next_r.nb = 4'h1;
                    next_r.tmr = per;
                    next_r.ts = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (tick && r.nb == 4'h8)
                begin
                    if (framed && par_en)
                    begin
                        next_r.mod = r.txp;
                        next_r.ts = TX_PAR;
                    end
                    else
                    begin
                        adv = 1'b1;
                    end
                end
                else if (tick)
                begin
                    next_r.mod = r.sh[r.nb[2:0]];
                    next_r.nb = r.nb + 4'h1;
                end
            end
            TX_PAR:
            begin
                adv = tick;
            end
            TX_EOF:
            begin
                if (tick)
                begin
                    next_r.ts = TX_IDLE;
                    next_r.mod = IDLE_LVL;
                    next_r.st.tx_done = 1'b1;
                end
            end
            default:
            begin
                next_r.ts = TX_IDLE;
            end
        endcase
        // byte finished: next payload, crc bytes or frame end
        if (adv)
        begin
            if (r.ph == PH_DATA)
            begin
                next_r.left = r.left - 1'b1;
                nph = (r.left == 13'h0001) ? (framed ? PH_CRC_LO : PH_DONE) : PH_DATA;
            end
            else
            begin
                nph = r.ph + 2'h1;
            end
            next_r.ph = nph;
            next_r.ts = (nph != PH_DONE) ? TX_LOAD : (framed ? TX_EOF : TX_IDLE);
            next_r.mod = (nph != PH_DONE) ? r.mod : (framed ? EOF_LVL : IDLE_LVL);
            next_r.st.tx_done = (nph == PH_DONE) && !framed;
        end
        // two-entry buffer after the fifo, so a stall loses nothing
        if (tx_pop || host_pop)
        begin
            next_r.bd = {8'h00, r.bd[15:8]};
            next_r.bv = {1'b0, r.bv[1]};
        end
        if (push)
        begin
            if (!next_r.bv[0])
            begin
                next_r.bd[7:0] = f_rd_data;
                next_r.bv[0] = 1'b1;
            end
            else
            begin
                next_r.bd[15:8] = f_rd_data;
                next_r.bv[1] = 1'b1;
            end
        end
        if (fifo_flush)
        begin
            next_r.bv = 2'h0;
        end
        // receive: raw sample packing or frame decoding
        if (rx_act && !framed)
        begin
            if (rx_bit_valid)
            begin
                next_r.rsh = {rx_bit, r.rsh[7:1]};
                next_r.rnb = (r.rnb == 4'h7) ? 4'h0 : r.rnb + 4'h1;
                next_r.rwr = (r.rnb == 4'h7);
                next_r.rdat = {rx_bit, r.rsh[7:1]};
            end
        end
        else if (rx_act)
        begin
            if (rx_frame && !r.rfp)
            begin
                next_r.rin = 1'b1;
                next_r.rsof = 1'b0;
                next_r.rnb = 4'h0;
                next_r.rcrc = crc_init;
                next_r.st.sof_err = 1'b0;
                next_r.st.eof_err = 1'b0;
                next_r.st.par_err = 1'b0;
                next_r.st.crc_err = 1'b0;
                next_r.st.ovf = 1'b0;
            end
            else if (!rx_frame && r.rfp && r.rin)
            begin
                next_r.rin = 1'b0;
                next_r.st.rx_done = 1'b1;
                next_r.st.eof_err = !r.rsof || r.rnb != 4'h0;
                next_r.st.crc_err = (r.rcrc != CRC_RESIDUE);
            end
            else if (r.rin && rx_bit_valid)
            begin
                if (!r.rsof)
                begin
                    next_r.rsof = 1'b1;
                    next_r.st.sof_err = (rx_bit != RX_SOF_BIT);
                end
                else if (r.rnb != 4'h8)
                begin
                    next_r.rsh = {rx_bit, r.rsh[7:1]};
                    next_r.rnb = r.rnb + 4'h1;
                    if (r.rnb == 4'h7 && !par_en)
                    begin
                        next_r.rnb = 4'h0;
                        next_r.rwr = 1'b1;
                        next_r.rdat = {rx_bit, r.rsh[7:1]};
                        next_r.rcrc = nfcfc_crc_byte(r.rcrc, {rx_bit, r.rsh[7:1]});
                    end
                end
                else
                begin
                    // parity bit checked and stripped; crc bytes stay
                    next_r.st.par_err = r.st.par_err || !(^{r.rsh, rx_bit});
                    next_r.rnb = 4'h0;
                    next_r.rwr = 1'b1;
                    next_r.rdat = r.rsh;
                    next_r.rcrc = nfcfc_crc_byte(r.rcrc, r.rsh);
                end
            end
        end
        // a byte dropped on a full fifo is flagged
        if (cfg.dir_rx && r.rwr && !f_wr_ready)
        begin
            next_r.st.ovf = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{ts: TX_IDLE, mod: IDLE_LVL, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sof_level_a: assert property (r.ts == TX_SOF |-> mod_out == SOF_LVL)
        else $error("start of frame not at its level");
    bit_period_a: assert property (r.ts == TX_SOF && $changed(r.ts) |-> r.tmr == per)
        else $error("bit period not taken from rate");
    stream_raw_a: assert property (cfg.mode == NFCFC_STREAM |-> r.ts != TX_SOF && r.ts != TX_PAR && r.ts != TX_EOF)
        else $error("stream transmit added framing");
    fetch_pop_a: assert property (r.ts == TX_LOAD && r.ph == PH_DATA ##1 r.ts == TX_DATA |-> $past(tx_pop))
        else $error("payload byte not taken from buffer");
    transp_tx_a: assert property (transp && !cfg.dir_rx |-> mod_out == spi_mosi)
        else $error("mosi not driving modulation");
    transp_rx_a: assert property (transp && cfg.dir_rx && !i2c_en |-> spi_miso == rx_bit && spi_miso_oe)
        else $error("subcarrier not on miso");
    i2c_quiet_a: assert property (i2c_en |-> !spi_miso_oe)
        else $error("miso driven in i2c selection");
    host_block_a: assert property (!osc_en |-> !host_wr_ready && !host_rd_valid)
        else $error("fifo reachable while powered down");
    host_open_a: assert property (osc_en && !cfg.dir_rx && f_wr_ready |-> host_wr_ready)
        else $error("fifo closed while ready");
    crc_flag_a: assert property (rx_act && framed && !rx_frame && r.rfp && r.rin && r.rcrc != CRC_RESIDUE |=> stat.crc_err)
        else $error("bad crc not flagged");
    rx_store_a: assert property (cfg.dir_rx && r.rwr |-> f_wr_valid && f_wr_data == r.rdat)
        else $error("received byte not offered to fifo");
    stream_pack_a: assert property (rx_act && !framed && rx_bit_valid && r.rnb == 4'h7 |=> r.rwr)
        else $error("eight samples not stored");
    tx_len_a: assert property (r.left <= LEN_W'(TX_MAX_BYTES))
        else $error("transmit length above limit");

    framed_tx_c: cover property (r.ts == TX_EOF ##1 r.ts == TX_IDLE);
    framed_rx_c: cover property (stat.rx_done && !stat.crc_err);
    buf_full_c: cover property (r.bv == 2'h3 && r.ts == TX_LOAD);

endmodule

// File: nfcfc_fifo.sv
/*
 * shared byte fifo with read and write pointers and a fill level.
 * assumes one writer and one reader selected outside by transfer direction.
 */
module nfcfc_fifo
    import nfcfc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_BYTES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
        $error("nfcfc_fifo: depth below 2 or zero width");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] lvl;
    } nfcfc_fifo_s;

    nfcfc_fifo_s r, next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // handshakes from the fill level
    assign wr_ready = (r.lvl != (AW+1)'(DEPTH));
    assign rd_valid = (r.lvl != '0);
    assign rd_data = mem[r.rp];
    assign level = r.lvl;
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    // pointers wrap at capacity, level tracks the difference
    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
        end
        if (pop)
        begin
            next_r.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
        end
        next_r.lvl = r.lvl + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            next_r = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // storage, no reset needed
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[r.wp] <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    fifo_cap_bound_a: assert property (level <= (AW+1)'(DEPTH))
        else $error("fifo level above capacity");
    level_tracks_a: assert property (!flush |=> level == $past(level) + (AW+1)'($past(push)) - (AW+1)'($past(pop)))
        else $error("fifo level does not follow push and pop");

endmodule

// File: nfcfc_host_model.sv
/* host model: takes bytes offered on the fifo read port, with random stalls.
   assumes the bench seeds $urandom and checks the data itself. */
module nfcfc_host_model
    import nfcfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rd_valid,
    output logic rd_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // stalls about one cycle in four, moves only after the falling edge
    initial rd_ready = 1'b0;
    always @(negedge sys_clk)
    begin
        rd_ready <= rst_n && ($urandom % 4 != 0);
    end
endmodule

// File: nfcfc_pkg.sv
/*
 * constants, enumerations, carrier structs and the crc step for the nfc
 * frame codec with its shared fifo.
 * assumes a 100 MHz system clock and inputs synchronous to it.
 */
package nfcfc_pkg;

    // ------------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------------
    localparam int FIFO_BYTES = 512;
    localparam int TX_MAX_BYTES = 8191;
    localparam int LEN_W = 13;
    localparam int CLK_NS = 10;
    localparam int BIT_NS = 9440;                        // base bit period
    localparam logic [11:0] BIT_CYC = 12'(BIT_NS / CLK_NS);

    // ------------------------------------------------------------------
    // crc and line levels
    // ------------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h8408;         // reflected 0x1021
    localparam logic [15:0] CRC_INIT_A = 16'h6363;
    localparam logic [15:0] CRC_INIT_X = 16'hffff;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam logic SOF_LVL = 1'b0;
    localparam logic EOF_LVL = 1'b0;
    localparam logic IDLE_LVL = 1'b1;
    localparam logic RX_SOF_BIT = 1'b1;
    localparam logic [1:0] PH_DATA = 2'h0;
    localparam logic [1:0] PH_CRC_LO = 2'h1;
    localparam logic [1:0] PH_CRC_HI = 2'h2;
    localparam logic [1:0] PH_DONE = 2'h3;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {NFCFC_FRAMED, NFCFC_STREAM, NFCFC_TRANSP} nfcfc_mode_e;
    typedef enum logic [1:0] {NFCFC_PROTO_A, NFCFC_PROTO_B, NFCFC_PROTO_F, NFCFC_PROTO_V} nfcfc_proto_e;
    typedef enum logic [2:0] {TX_IDLE, TX_SOF, TX_LOAD, TX_DATA, TX_PAR, TX_EOF} nfcfc_tx_e;

    typedef struct packed {
        nfcfc_mode_e mode;
        nfcfc_proto_e proto;
        logic [1:0] rate;                                // bit period = base >> rate
        logic dir_rx;                                    // 1: fifo holds received data
        logic [LEN_W-1:0] tx_len;                        // payload bytes of next frame
    } nfcfc_cfg_s;

    typedef struct packed {
        logic tx_done;
        logic rx_done;
        logic sof_err;
        logic eof_err;
        logic par_err;
        logic crc_err;
        logic ovf;
    } nfcfc_stat_s;

    // byte-wide reflected crc step, lsb first
    function automatic logic [15:0] nfcfc_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 0; i < 8; i++)
        begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

endpackage
